// *** hw/pfs_pkg.sv ***
// package: register map, bit positions and event carriers of the fault status bank
//
// Notes on behaviour
// (RULE1) vout byte: bit7 ov fault, bit4 uv fault
// (RULE2) vout warnings bits 6/5, blocked by faults
// (RULE3) vout bit3 on out-of-range setpoint write
// (RULE4) iout byte: bit7 oc fault, bit4 uc fault
// (RULE5) iout bit5 oc warning, blocked by fault
// (RULE6) input byte: bit7 ov fault, bit4 uv fault
// (RULE7) input warnings bits 6/5, blocked by faults
// (RULE8) temperature byte: bit7 ot, bit4 ut fault
// (RULE9) temperature warnings bits 6/5, blocked by faults
// (RULE10) cml bit7 on invalid command code
// (RULE11) cml bit6 on invalid data values
// (RULE12) cml bit5 on packet error check failure
// (RULE13) cml bit1 on protected write or bad length
// (RULE14) cml bits clear only by clear or re-enable
// (RULE15) five read-only bytes, reset to zero
// (RULE16) host must not expect warning with fault
// (RULE17) unused bits always read zero
// (RULE18) summary bits 15/14/13 from vout/iout/input bytes
// (RULE19) summary bit1 whenever cml byte nonzero
package pfs_pkg;

	// ********************************************************
	// register offsets (command codes)
	// ********************************************************
	localparam logic [7:0] PFS_OFS_VOUT  = 8'h7A;
	localparam logic [7:0] PFS_OFS_IOUT  = 8'h7B;
	localparam logic [7:0] PFS_OFS_INPUT = 8'h7C;
	localparam logic [7:0] PFS_OFS_TEMP  = 8'h7D;
	localparam logic [7:0] PFS_OFS_CML   = 8'h7E;
	localparam logic [7:0] PFS_RST_VAL   = 8'h00;

	// ********************************************************
	// bit positions and writable-bit masks
	// ********************************************************
	localparam int PFS_B_OVF = 7;
	localparam int PFS_B_OVW = 6;
	localparam int PFS_B_UVW = 5;
	localparam int PFS_B_UVF = 4;
	localparam int PFS_B_MAX = 3;
	localparam int PFS_B_OCW = 5;
	localparam int PFS_B_CMD = 7;
	localparam int PFS_B_DAT = 6;
	localparam int PFS_B_PEC = 5;
	localparam int PFS_B_ACC = 1;
	localparam logic [7:0] PFS_MSK_VOUT = 8'hF8;
	localparam logic [7:0] PFS_MSK_IOUT = 8'hB0;
	localparam logic [7:0] PFS_MSK_4B   = 8'hF0;
	localparam logic [7:0] PFS_MSK_CML  = 8'hE2;
	// summary word bit positions
	localparam int PFS_S_VOUT = 15;
	localparam int PFS_S_IOUT = 14;
	localparam int PFS_S_INP  = 13;
	localparam int PFS_S_CML  = 1;

	// ********************************************************
	// carriers
	// ********************************************************
	// one protection channel: fault levels and warning levels
	typedef struct packed {
		logic ov_fault;
		logic ov_warn;
		logic uv_warn;
		logic uv_fault;
	} pfs_chan_t;

	// communication events, one-cycle pulses
	typedef struct packed {
		logic bad_cmd;
		logic bad_data;
		logic pec_fail;
		logic bad_access;
	} pfs_cml_ev_t;

	// the five status bytes
	typedef struct packed {
		logic [7:0] vout;
		logic [7:0] iout;
		logic [7:0] inp;
		logic [7:0] temp;
		logic [7:0] cml;
	} pfs_regs_t;

endpackage

// *** hw/pfs_latch.sv ***
// one sticky status byte: masked set inputs, set wins over clear
module pfs_latch
	import pfs_pkg::*;
(
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	// control
	input  wire logic [7:0] i_set,
	input  wire logic [7:0] i_mask,
	input  wire logic       i_clear,
	// state
	output logic      [7:0] o_val
);

	typedef struct packed {
		logic [7:0] val_ff;
	} pfs_lat_st_t;

	pfs_lat_st_t st_ff;   // registered state
	pfs_lat_st_t nxt_st;  // next state

	// set wins over clear so a coincident event is kept
	always_comb begin
		nxt_st = st_ff;
		if (i_clear) begin
			nxt_st.val_ff = PFS_RST_VAL;
		end
		nxt_st.val_ff = (nxt_st.val_ff | i_set) & i_mask; // RULE17
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff.val_ff <= PFS_RST_VAL; // RULE15
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_val = st_ff.val_ff;

	a_unused_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(o_val & ~i_mask) == 8'h00) else $error("unused status bit set"); // RULE17

endmodule

// *** hw/pfs_status.sv ***
// fault status bank: five sticky status bytes and the summary word
module pfs_status
	import pfs_pkg::*;
(
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	// protection channels (levels)
	input  pfs_chan_t        i_vout,
	input  pfs_chan_t        i_iout,
	input  pfs_chan_t        i_vin,
	input  pfs_chan_t        i_temp,
	// setpoint write events (pulses)
	input  wire logic        i_vset_wr,
	input  wire logic        i_vset_range_bad,
	// command interface events (pulses) and enable level
	input  pfs_cml_ev_t      i_cml_ev,
	input  wire logic        i_clear_faults,
	input  wire logic        i_enable,
	// read port
	input  wire logic [7:0]  i_rd_cmd,
	output logic      [7:0]  o_rd_data,
	output logic             o_rd_hit,
	// summary
	output logic      [15:0] o_summary
);

	// ********************************************************
	// state
	// ********************************************************
	typedef struct packed {
		logic       en_ff;    // last enable level
		logic [7:0] rd_ff;    // read data register
		logic       hit_ff;   // read command decoded
	} pfs_st_t;

	pfs_st_t    st_ff;        // registered state
	pfs_st_t    nxt_st;       // next state
	pfs_regs_t  regs;         // current byte values
	logic [7:0] set_vout;     // set vectors per byte
	logic [7:0] set_iout;
	logic [7:0] set_inp;
	logic [7:0] set_temp;
	logic [7:0] set_cml;
	logic       clr_all;      // clear-faults command
	logic       clr_cml;      // clear or re-enable

	// fault bits plus warnings gated by their own faults
	function automatic logic [7:0] chan_set(input pfs_chan_t c);
		logic [7:0] s;
		s = 8'h00;
		s[PFS_B_OVF] = c.ov_fault;
		s[PFS_B_UVF] = c.uv_fault;
		s[PFS_B_OVW] = c.ov_warn & ~c.ov_fault;
		s[PFS_B_UVW] = c.uv_warn & ~c.uv_fault;
		return s;
	endfunction

	// ********************************************************
	// set vectors
	// ********************************************************
	always_comb begin
		set_vout = chan_set(i_vout);                            // RULE1 RULE2
		set_vout[PFS_B_MAX] = i_vset_wr & i_vset_range_bad;     // RULE3
		set_iout = 8'h00;
		set_iout[PFS_B_OVF] = i_iout.ov_fault;                 // RULE4
		set_iout[PFS_B_UVF] = i_iout.uv_fault;                 // RULE4
		set_iout[PFS_B_OCW] = i_iout.ov_warn & ~i_iout.ov_fault; // RULE5
		set_inp  = chan_set(i_vin);                             // RULE6 RULE7
		set_temp = chan_set(i_temp);                            // RULE8 RULE9
		set_cml  = 8'h00;
		set_cml[PFS_B_CMD] = i_cml_ev.bad_cmd;                  // RULE10
		set_cml[PFS_B_DAT] = i_cml_ev.bad_data;                 // RULE11
		set_cml[PFS_B_PEC] = i_cml_ev.pec_fail;                 // RULE12
		set_cml[PFS_B_ACC] = i_cml_ev.bad_access;               // RULE13
	end

	// clear-faults clears all; re-enable edge clears communication byte
	assign clr_all = i_clear_faults;
	assign clr_cml = i_clear_faults | (i_enable & ~st_ff.en_ff); // RULE14

	// ********************************************************
	// status bytes
	// ********************************************************
	pfs_latch u_vout (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_set   (set_vout),
		.i_mask  (PFS_MSK_VOUT),
		.i_clear (clr_all),
		.o_val   (regs.vout)
	);
	pfs_latch u_iout (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_set   (set_iout),
		.i_mask  (PFS_MSK_IOUT),
		.i_clear (clr_all),
		.o_val   (regs.iout)
	);
	pfs_latch u_inp (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_set   (set_inp),
		.i_mask  (PFS_MSK_4B),
		.i_clear (clr_all),
		.o_val   (regs.inp)
	);
	pfs_latch u_temp (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_set   (set_temp),
		.i_mask  (PFS_MSK_4B),
		.i_clear (clr_all),
		.o_val   (regs.temp)
	);
	pfs_latch u_cml (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_set   (set_cml),
		.i_mask  (PFS_MSK_CML),
		.i_clear (clr_cml),
		.o_val   (regs.cml)
	);

	// ********************************************************
	// read decode and enable tracking
	// ********************************************************
	// read data is registered; no write path exists, the bytes are read-only
	always_comb begin
		nxt_st = st_ff;
		nxt_st.en_ff = i_enable;
		nxt_st.hit_ff = 1'b1;
		unique case (i_rd_cmd)
			PFS_OFS_VOUT:  nxt_st.rd_ff = regs.vout;
			PFS_OFS_IOUT:  nxt_st.rd_ff = regs.iout;
			PFS_OFS_INPUT: nxt_st.rd_ff = regs.inp;
			PFS_OFS_TEMP:  nxt_st.rd_ff = regs.temp;
			PFS_OFS_CML:   nxt_st.rd_ff = regs.cml;
			default: begin
				nxt_st.rd_ff = 8'h00;
				nxt_st.hit_ff = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_rd_data = st_ff.rd_ff;
	assign o_rd_hit  = st_ff.hit_ff;

	// summary word; other bits belong to logic outside this bank
	always_comb begin
		o_summary = 16'h0000;
		o_summary[PFS_S_VOUT] = |regs.vout; // RULE18
		o_summary[PFS_S_IOUT] = |regs.iout; // RULE18
		o_summary[PFS_S_INP]  = |regs.inp;  // RULE18
		o_summary[PFS_S_CML]  = |regs.cml;  // RULE19
	end

	// ********************************************************
	// assertions
	// ********************************************************
	a_vout_ov_fault: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE1
		i_vout.ov_fault && !i_clear_faults |=> regs.vout[PFS_B_OVF])
		else $error("vout overvoltage fault not latched");
	a_vout_warn_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE2
		i_clear_faults && i_vout.ov_fault |=> !regs.vout[PFS_B_OVW])
		else $error("vout warning set during fault");
	a_vout_max_set: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE3
		i_vset_wr && i_vset_range_bad |=> regs.vout[PFS_B_MAX])
		else $error("setpoint range flag not set");
	a_iout_uc_fault: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE4
		i_iout.uv_fault |=> regs.iout[PFS_B_UVF])
		else $error("undercurrent fault not latched");
	a_iout_warn_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE5
		i_clear_faults && i_iout.ov_fault |=> !regs.iout[PFS_B_OCW])
		else $error("oc warning set during fault");
	a_vin_fault: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE6
		i_vin.uv_fault |=> regs.inp[PFS_B_UVF])
		else $error("input uv fault not latched");
	a_vin_warn: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE7
		i_vin.ov_warn && !i_vin.ov_fault |=> regs.inp[PFS_B_OVW])
		else $error("input ov warning not latched");
	a_temp_fault: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE8
		i_temp.ov_fault |=> regs.temp[PFS_B_OVF])
		else $error("over-temperature fault not latched");
	a_temp_warn_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE9
		i_clear_faults && i_temp.uv_fault |=> !regs.temp[PFS_B_UVW])
		else $error("temperature warning set during fault");
	a_cml_cmd_set: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE10
		i_cml_ev.bad_cmd |=> regs.cml[PFS_B_CMD])
		else $error("bad command not recorded");
	a_cml_data_set: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE11
		i_cml_ev.bad_data |=> regs.cml[PFS_B_DAT])
		else $error("bad data not recorded");
	a_cml_pec_set: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE12
		i_cml_ev.pec_fail |=> regs.cml[PFS_B_PEC])
		else $error("pec failure not recorded");
	a_cml_acc_set: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE13
		i_cml_ev.bad_access |=> regs.cml[PFS_B_ACC])
		else $error("access error not recorded");
	// without a clear or re-enable no set bit of the byte may drop
	a_cml_sticky: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE14
		!clr_cml |=> (regs.cml & $past(regs.cml)) == $past(regs.cml))
		else $error("cml bit lost without clear");
	a_read_byte: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE15
		i_rd_cmd == PFS_OFS_CML |=> o_rd_hit && o_rd_data == $past(regs.cml))
		else $error("cml read data mismatch");
	a_summary_bits: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE18
		o_summary[PFS_S_VOUT] == (regs.vout != 8'h00))
		else $error("summary vout bit wrong");
	a_summary_cml: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE19
		i_cml_ev.pec_fail |=> o_summary[PFS_S_CML])
		else $error("summary cml bit missing");

	// ********************************************************
	// remaining set paths, warning gates, clears and reads
	// ********************************************************
	// output voltage byte: the other fault, a warning, and the second gate
	a_vout_uv_fault: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE1
		i_vout.uv_fault |=> regs.vout[PFS_B_UVF])
		else $error("vout undervoltage fault not latched");
	a_vout_ovw_set: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE2
		i_vout.ov_warn && !i_vout.ov_fault |=> regs.vout[PFS_B_OVW])
		else $error("vout overvoltage warning not latched");
	a_vout_uvw_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE2
		i_clear_faults && i_vout.uv_fault |=> !regs.vout[PFS_B_UVW])
		else $error("vout uv warning set during fault");
	// the range flag is a one-shot event, so it must survive until a clear
	a_vout_max_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE3
		!i_clear_faults && regs.vout[PFS_B_MAX] |=> regs.vout[PFS_B_MAX])
		else $error("setpoint range flag lost");

	// output current byte
	a_iout_oc_set: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE4
		i_iout.ov_fault |=> regs.iout[PFS_B_OVF])
		else $error("overcurrent fault not latched");
	a_iout_warn_set: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE5
		i_iout.ov_warn && !i_iout.ov_fault |=> regs.iout[PFS_B_OCW])
		else $error("oc warning not latched");

	// input voltage byte
	a_vin_ov_fault: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE6
		i_vin.ov_fault |=> regs.inp[PFS_B_OVF])
		else $error("input ov fault not latched");
	a_vin_ovw_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE7
		i_clear_faults && i_vin.ov_fault |=> !regs.inp[PFS_B_OVW])
		else $error("input ov warning set during fault");
	a_vin_uvw_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE7
		i_clear_faults && i_vin.uv_fault |=> !regs.inp[PFS_B_UVW])
		else $error("input uv warning set during fault");

	// temperature byte
	a_temp_ut_fault: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE8
		i_temp.uv_fault |=> regs.temp[PFS_B_UVF])
		else $error("under-temperature fault not latched");
	a_temp_otw_set: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE9
		i_temp.ov_warn && !i_temp.ov_fault |=> regs.temp[PFS_B_OVW])
		else $error("over-temperature warning not latched");
	a_temp_otw_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE9
		i_clear_faults && i_temp.ov_fault |=> !regs.temp[PFS_B_OVW])
		else $error("over-temperature warning set during fault");

	// communication byte: both ways of emptying it, when no event competes
	a_cml_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE14
		i_clear_faults && i_cml_ev == '0 |=> regs.cml == 8'h00)
		else $error("cml byte not emptied by clear");
	a_cml_reenable: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE14
		i_enable && !st_ff.en_ff && i_cml_ev == '0 |=> regs.cml == 8'h00)
		else $error("cml byte not emptied by re-enable");

	// reads: every mapped code returns its byte as of the sampling edge
	a_read_vout: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE15
		i_rd_cmd == PFS_OFS_VOUT |=> o_rd_hit && o_rd_data == $past(regs.vout))
		else $error("vout read data mismatch");
	a_read_iout: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE15
		i_rd_cmd == PFS_OFS_IOUT |=> o_rd_hit && o_rd_data == $past(regs.iout))
		else $error("iout read data mismatch");
	a_read_input: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE15
		i_rd_cmd == PFS_OFS_INPUT |=> o_rd_hit && o_rd_data == $past(regs.inp))
		else $error("input read data mismatch");
	a_read_temp: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE15
		i_rd_cmd == PFS_OFS_TEMP |=> o_rd_hit && o_rd_data == $past(regs.temp))
		else $error("temperature read data mismatch");
	// unmapped codes must neither hit nor leak a stale byte
	a_read_miss: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE15
		i_rd_cmd < PFS_OFS_VOUT || i_rd_cmd > PFS_OFS_CML |=> !o_rd_hit && o_rd_data == 8'h00)
		else $error("unmapped code answered");

	// summary word: the remaining owned bits, and silence on bits owned elsewhere
	a_summary_iout: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE18
		o_summary[PFS_S_IOUT] == (regs.iout != 8'h00))
		else $error("summary iout bit wrong");
	a_summary_inp: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE18
		o_summary[PFS_S_INP] == (regs.inp != 8'h00))
		else $error("summary input bit wrong");
	a_summary_rest: assert property (@(posedge i_mclk) disable iff (!i_rstn) // RULE18
		(o_summary & 16'h1FFD) == 16'h0000)
		else $error("summary foreign bit set");

endmodule

// *** tb/pfs_host.sv ***
// host model: issues status reads and hands back each answered byte
module pfs_host
	import pfs_pkg::*;
(
	// clock
	input  wire logic       i_mclk,
	// bench side
	input  wire logic       i_req,
	input  wire logic [7:0] i_cmd,
	output logic            o_valid,
	output logic      [8:0] o_res,
	// device side
	output logic      [7:0] o_rd_cmd,
	input  wire logic [7:0] i_rd_data,
	input  wire logic       i_rd_hit
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] cmd_ff = 8'h00; // code held for the device
	logic       v1_ff  = 1'b0;  // code is presented at this edge
	logic       v2_ff  = 1'b0;  // answer is due at this edge

	// ********************************************************
	// read pipeline
	// ********************************************************
	// outside its edge the code shows its inverse, so a stale code never passes
	assign o_rd_cmd = v1_ff ? cmd_ff : ~cmd_ff;
	assign o_valid  = v2_ff;
	// bytes are passed on as read, warnings with faults are not assumed
	assign o_res    = {i_rd_hit, i_rd_data};

	// one request per cycle, back to back allowed
	always @(posedge i_mclk) begin
		cmd_ff <= i_req ? i_cmd : cmd_ff;
		v1_ff  <= i_req;
		v2_ff  <= v1_ff;
	end
endmodule

// *** tb/pfs_status_test.sv ***
// bench: random protection and command events, sticky bytes read back
module pfs_status_test
	import pfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end

	logic        mclk = 1'b0; // system clock
	logic        rstn = 1'b0; // active-low reset
	pfs_chan_t   ch[4];       // vout, iout, input, temp levels
	logic        vset_wr;     // setpoint write pulse
	logic        vset_bad;    // setpoint out of range
	pfs_cml_ev_t ev;          // command events
	logic        clr;         // clear-faults pulse
	logic        en;          // output enable level
	logic        en_prev;     // enable as last driven
	logic        req;         // read request to host
	logic [7:0]  cmd;         // code to read
	logic [7:0]  rd_cmd;
	logic [7:0]  rd_data;
	logic        rd_hit;
	logic [15:0] summ;
	logic        h_valid;
	logic [8:0]  h_res;
	logic [8:0]  nt;          // oldest note
	logic [7:0]  ex[5];       // expected bytes
	logic [8:0]  q[$];        // expected read results
	int          fails = 0;
	int          n_checks = 0;
	int          cyc = 0;

	pfs_status i_pfs_status (.i_mclk(mclk), .i_rstn(rstn), .i_vout(ch[0]), .i_iout(ch[1]),
		.i_vin(ch[2]), .i_temp(ch[3]), .i_vset_wr(vset_wr), .i_vset_range_bad(vset_bad),
		.i_cml_ev(ev), .i_clear_faults(clr), .i_enable(en), .i_rd_cmd(rd_cmd),
		.o_rd_data(rd_data), .o_rd_hit(rd_hit), .o_summary(summ));
	pfs_host i_pfs_host (.i_mclk(mclk), .i_req(req), .i_cmd(cmd), .o_valid(h_valid),
		.o_res(h_res), .o_rd_cmd(rd_cmd), .i_rd_data(rd_data), .i_rd_hit(rd_hit));

	// ********************************************************
	// helpers
	// ********************************************************
	// upper nibble of a two-sided channel: warning blocked by its own fault
	function automatic logic [3:0] wb(input pfs_chan_t c);
		return {c.ov_fault, c.ov_warn & ~c.ov_fault, c.uv_warn & ~c.uv_fault, c.uv_fault};
	endfunction

	// one cycle of events, then the expected sticky bytes are advanced
	task automatic step(input pfs_chan_t v0, v1, v2, v3, input logic w, b,
		input pfs_cml_ev_t e, input logic c, n);
		logic [7:0] s[5];
		s[0] = {wb(v0), w & b, 3'h0};
		s[1] = {v1.ov_fault, 1'b0, v1.ov_warn & ~v1.ov_fault, v1.uv_fault, 4'h0};
		s[2] = {wb(v2), 4'h0};
		s[3] = {wb(v3), 4'h0};
		s[4] = {e.bad_cmd, e.bad_data, e.pec_fail, 3'h0, e.bad_access, 1'b0};
		ch = '{v0, v1, v2, v3};
		{vset_wr, vset_bad, ev, clr, en} = {w, b, e, c, n};
		@(negedge mclk);
		ch = '{4'h0, 4'h0, 4'h0, 4'h0};
		{vset_wr, vset_bad, ev, clr} = '0;
		// set wins over clear; enable rise clears only the command byte
		for (int k = 0; k < 5; k++)
			ex[k] = ((c || (k == 4 && n && !en_prev)) ? 8'h00 : ex[k]) | s[k];
		en_prev = n;
	endtask

	// one read request; the caller lowers the request afterwards
	task automatic rd(input logic [7:0] c, input logic [8:0] e);
		req = 1'b1;
		cmd = c;
		q.push_back(e);
		@(negedge mclk);
	endtask

	// all five bytes back to back, then the summary
	task automatic rd_all;
		for (int k = 0; k < 5; k++)
			rd(8'(PFS_OFS_VOUT + k), {1'b1, ex[k]});
		req = 1'b0;
		repeat (3) @(negedge mclk);
		`CHK(summ, {|ex[0], |ex[1], |ex[2], 11'h0, |ex[4], 1'b0})
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ********************************************************
	// clock, monitor and timeout
	// ********************************************************
	initial begin
		forever #5 mclk = ~mclk;
	end

	// each answer from the host is matched with the oldest note
	always @(posedge mclk) begin
		if (h_valid === 1'b1) begin
			nt = q.pop_front();
			`CHK(h_res, nt)
		end
	end

	// the run needs well under 1000 cycles; a hang counts as a mismatch
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			wrap_up();
		end
	end

	// ********************************************************
	// main sequence
	// ********************************************************
	initial begin
		ch = '{4'h0, 4'h0, 4'h0, 4'h0};
		{vset_wr, vset_bad, ev, clr, req, cmd} = '0;
		en = 1'b1;
		en_prev = 1'b1;
		ex = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		void'($urandom(32'hBAEB));
		repeat (3) @(negedge mclk);
		rstn = 1'b1;
		// unmapped codes answer zero without a hit
		rd(8'h79, 9'h000);
		rd(8'h7F, 9'h000);
		rd_all();
		// random levels and events; clear every tenth step, random enable toggles
		for (int i = 0; i < 60; i++) begin
			step(4'($urandom), 4'($urandom), 4'($urandom), 4'($urandom), 1'($urandom),
				1'($urandom), 4'($urandom), (i % 10) == 9, 1'($urandom));
			rd_all();
		end
		// a reset in mid-run brings every byte back to zero
		rstn = 1'b0;
		repeat (2) @(negedge mclk);
		rstn = 1'b1;
		ex = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		rd_all();
		repeat (4) @(negedge mclk);
		wrap_up();
	end
endmodule
